/* dv/morc_core_monitor.sv */
// Concurrent checks on the ports of the settings and result buffer core.
// Assumes one clock domain and a core built with CYC_PER_MS of 4.
`timescale 1ns/100ps
module morc_core_monitor #(
  parameter int unsigned CYC_PER_MS = 4  // Cycles per millisecond of the core.
) (
  input wire logic                   mclk,
  input wire logic                   rst_n,
  input wire logic                   clk_en,
  input wire logic                   cmd_set,
  input wire logic                   cmd_query,
  input wire morc_pkg::morc_cmd_t    cmd,
  input wire logic                   sys_reset_cmd,
  input wire logic                   meas_done,
  input wire logic                   tx_valid,
  input wire morc_pkg::morc_txword_t tx_word,
  input wire logic                   in_ready,
  input wire logic                   auto_send_en,
  input wire logic                   shorted_probe_check_enable,
  input wire logic [7:0]             shorted_probe_check_delay,
  input wire logic                   probe_check_start,
  input wire logic                   nvm_save,
  input wire logic                   cmd_error
);
  // Every check shares the one clock and is quiet while reset is held.
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!rst_n);

  // Set commands that a system reset in the same cycle would override are left out.
  wire logic set_ok = cmd_set && clk_en && !sys_reset_cmd;

  auto_send_set_a: assert property (set_ok && cmd.sel == 3'h0 |=>
    auto_send_en == ($past(cmd.value) == 8'h01)) else $error("auto send setting wrong");
  probe_en_set_a: assert property (set_ok && cmd.sel == 3'h2 |=>
    shorted_probe_check_enable == ($past(cmd.value) == 8'h01)) else $error("probe enable wrong");
  probe_dly_set_a: assert property (set_ok && cmd.sel == 3'h3 &&
    cmd.value inside {[8'h01:8'h64]} |=> shorted_probe_check_delay == $past(cmd.value))
    else $error("probe delay not taken");
  probe_dly_bad_a: assert property (set_ok && cmd.sel == 3'h3 &&
    (cmd.value == 8'h00 || cmd.value > 8'h64) |=> cmd_error && $stable(shorted_probe_check_delay))
    else $error("bad probe delay accepted");
  probe_start_time_a: assert property (meas_done && clk_en &&
    shorted_probe_check_enable && shorted_probe_check_delay == 8'h01 |=>
    !probe_check_start [*2] ##[1:4] probe_check_start) else $error("probe check mistimed");
  sys_defaults_a: assert property (sys_reset_cmd && clk_en && !cmd_set |=> !auto_send_en &&
    !shorted_probe_check_enable && shorted_probe_check_delay == 8'h0A)
    else $error("defaults not restored");
  nvm_store_a: assert property (sys_reset_cmd && clk_en |=> ##1 nvm_save)
    else $error("settings not stored");
  binary_delim_a: assert property (tx_valid |-> tx_word.delim == !tx_word.binary)
    else $error("delimiter flag wrong");
  full_holds_a: assert property (!in_ready |-> tx_valid) else $error("full but empty");

  // Main scenarios reached.
  cover property (sys_reset_cmd ##2 nvm_save);
  cover property (probe_check_start);
  cover property (!in_ready);
endmodule // morc_core_monitor

bind morc_core morc_core_monitor #(.CYC_PER_MS(CYC_PER_MS)) mon_u (.mclk, .rst_n, .clk_en,
  .cmd_set, .cmd_query, .cmd, .sys_reset_cmd, .meas_done, .tx_valid, .tx_word, .in_ready,
  .auto_send_en, .shorted_probe_check_enable, .shorted_probe_check_delay,
  .probe_check_start, .nvm_save, .cmd_error);

/* dv/morc_tx_sink.sv */
// Model of the transmitter that takes words from the result buffer.
// Assumes the valid and ready handshake of the core; mode picks how fast it takes.
`timescale 1ns/100ps
module morc_tx_sink (
  input wire logic                   mclk,
  input wire logic                   rst_n,
  input wire logic                   tx_valid,
  input wire morc_pkg::morc_txword_t tx_word,
  input wire logic [1:0]             mode,     // 0 prompt, 1 random, 2 stalled.
  output logic                       tx_ready,
  output logic                       got,      // One cycle per word taken.
  output morc_pkg::morc_txword_t     got_word
);
  // Ready moves off the sampling edge, so a stall never races the core.
  always @(negedge mclk) begin
    if (!rst_n || mode == 2'h2) tx_ready <= 1'b0;
    else if (mode == 2'h1) tx_ready <= ($urandom % 4) == 0;
    else tx_ready <= 1'b1;
  end

  // A word counts as taken at the edge where valid and ready are both high.
  always @(posedge mclk) begin
    got      <= rst_n && tx_valid && tx_ready;
    got_word <= tx_word;
  end
endmodule // morc_tx_sink

/* dv/testbench.sv */
// Self-checking bench for the settings core with a transmitter model.
// Assumes the core runs with CYC_PER_MS of 4; clk_en is high except during one set.
`timescale 1ns/100ps
module testbench;
  logic                   mclk = 1'b0, rst_n = 1'b0, cmd_set = 1'b0, cmd_query = 1'b0;
  logic                   sys_reset_cmd = 1'b0, trigger_input_signal_internal = 1'b0, meas_done = 1'b0;
  logic                   trigger_input_signal = 1'b0, host_fetch = 1'b0;
  logic                   host_fetch_gpib = 1'b0, bin_e = 1'b0, clk_en = 1'b1;
  logic [1:0]             mode = 2'h0;
  morc_pkg::morc_cmd_t    cmd = '0;
  morc_pkg::morc_result_t meas_result = '0, last = '0;
  logic                   tx_valid, in_ready, tx_ready, got, auto_send_en, sp_en;
  logic                   probe_check_start, meas_restart, nvm_save, cmd_error, query_valid;
  logic [7:0]             sp_dly, query_data;
  morc_pkg::morc_txword_t tx_word, got_word;
  logic [7:0]             qq[$];  // Expected query answers.
  morc_pkg::morc_txword_t tq[$];  // Expected transmitted words.
  logic [7:0]             defs[6] = '{8'h00, 8'h00, 8'h00, 8'h0A, 8'h00, 8'h0A};
  int                     n_errors = 0, cmp_count = 0, k, seed;

  always #4 mclk = ~mclk;

  morc_core #(.CYC_PER_MS(4)) dut_u (.mclk, .rst_n, .clk_en, .cmd_set, .cmd_query,
    .cmd, .sys_reset_cmd, .trigger_input_signal_internal, .trigger_input_signal, .meas_done, .meas_result,
    .host_fetch, .host_fetch_gpib, .tx_ready, .tx_valid, .tx_word, .in_ready, .auto_send_en,
    .shorted_probe_check_enable(sp_en), .shorted_probe_check_delay(sp_dly), .probe_check_start,
    .meas_restart, .nvm_save, .cmd_error, .query_valid, .query_data);
  morc_tx_sink sink_u (.mclk, .rst_n, .tx_valid, .tx_word, .mode, .tx_ready, .got, .got_word);

  // Reports a mismatch at once and counts every comparison.
  task automatic chk(input logic [35:0] seen, input logic [35:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      n_errors++;
      $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  task automatic tick(input int n = 1);
    repeat (n) @(negedge mclk);
  endtask

  // Each strobe stays low for one edge before the next request raises it again.
  task automatic set(input int s, input logic [7:0] v);
    cmd = '{3'(s), v}; cmd_set = 1'b1; tick(); cmd_set = 1'b0; tick();
  endtask

  task automatic qry(input int s, input logic [7:0] e);
    qq.push_back(e); cmd = '{3'(s), 8'h00}; cmd_query = 1'b1; tick();
    cmd_query = 1'b0; tick();
  endtask

  // A word is only expected while the buffer shows room, as a full one drops it.
  task automatic expect_word(input logic g);
    if (in_ready === 1'b1) tq.push_back('{last.data, last.fault, bin_e, !bin_e, g});
  endtask

  task automatic meas(input logic f, input logic push, input logic rep);
    meas_result = '{$urandom, f};
    if (rep) last = meas_result;
    if (push) expect_word(1'b0);
    meas_done = 1'b1; tick(); meas_done = 1'b0; tick();
  endtask

  task automatic fetch(input logic g);
    expect_word(g); host_fetch = 1'b1; host_fetch_gpib = g; tick(); host_fetch = 1'b0; tick();
  endtask

  // Waits for the expected words to leave, then for any stray word to show.
  task automatic drain(input string name);
    for (k = 0; k < 300 && tq.size() != 0; k++) tick();
    tick(12);
    chk(36'(tq.size()), 36'h0);
    $display("test %s done", name);
  endtask

  // Takes the oldest note off a queue whenever a result shows at the outputs.
  always @(negedge mclk) begin
    if (query_valid === 1'b1) chk(query_data, qq.size() != 0 ? qq.pop_front() : 'x);
    if (got === 1'b1) chk(got_word, tq.size() != 0 ? tq.pop_front() : 'x);
  end

  task automatic give_verdict;
    $display("comparisons %0d mismatches %0d", cmp_count, n_errors);
    if (n_errors == 0 && cmp_count > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask

  initial begin
    #100000;
    n_errors++;
    give_verdict();
  end

  initial begin
    seed = $urandom(14);
    tick(2); rst_n = 1'b1; tick(4);
    for (int s = 0; s < 6; s++) qry(3'(s), defs[s]);
    drain("defaults");
    // Legal values round trip; boundary values are taken, and refused delays leave the old value.
    for (int s = 0; s < 6; s++) begin
      k = (s == 3) ? 1 + $urandom % 100 : (s == 5) ? 1 + $urandom % 50 : $urandom % 2;
      set(3'(s), 8'(k)); qry(3'(s), 8'(k));
    end
    set(3, 8'h64); set(3, 8'h00); set(3, 8'h65); qry(3, 8'h64);
    set(5, 8'h32); set(5, 8'h33); qry(5, 8'h32); set(5, 8'h00); qry(5, 8'h32);
    set(2, 8'h00); set(4, 8'h00);
    drain("settings");
    // The sink copes with raw words, so binary is picked first.
    set(0, 8'h01); set(1, 8'h01); bin_e = 1'b1;
    meas(1'b0, 1'b1, 1'b1); meas(1'b0, 1'b1, 1'b1);
    set(1, 8'h00); bin_e = 1'b0; meas(1'b0, 1'b1, 1'b1);
    set(0, 8'h00); meas(1'b0, 1'b0, 1'b1);
    fetch(1'b1); tick(); fetch(1'b0);
    drain("auto send");
    set(0, 8'h01); trigger_input_signal_internal = 1'b1; meas(1'b0, 1'b0, 1'b1);
    tick(4); expect_word(1'b0); trigger_input_signal = 1'b1; tick(3);
    trigger_input_signal = 1'b0; drain("internal trigger"); trigger_input_signal_internal = 1'b0;
    mode = 2'h2;
    repeat (3) meas(1'b0, 1'b1, 1'b1);
    chk(in_ready, 1'b0);
    mode = 2'h1; drain("buffer");
    mode = 2'h0; set(4, 8'h01); set(5, 8'h01); meas(1'b1, 1'b0, 1'b0);
    for (k = 0; k < 20 && meas_restart !== 1'b1; k++) tick();
    // One millisecond is four cycles, and meas has already spent one of them.
    chk(36'(k), 36'h3);
    meas(1'b1, 1'b1, 1'b1); drain("retry");
    set(2, 8'h01); set(3, 8'h01); meas(1'b0, 1'b1, 1'b1);
    for (k = 0; k < 20 && probe_check_start !== 1'b1; k++) tick();
    chk(36'(k), 36'h3);
    drain("probe check");
    sys_reset_cmd = 1'b1; tick(); sys_reset_cmd = 1'b0; tick(2);
    for (int s = 0; s < 6; s++) qry(3'(s), defs[s]);
    // A set made while the enable is low must not land.
    clk_en = 1'b0; set(2, 8'h01); clk_en = 1'b1; qry(2, 8'h00);
    meas(1'b0, 1'b0, 1'b1); drain("system reset");
    give_verdict();
  end
endmodule // testbench

/* logic/morc_core.sv */
// Settings for result output, shorted-probe check and retry, with a result buffer.
// Assumes measurement, trigger source and host command logic share mclk; the trigger
// pin is asynchronous and is synchronised here.
//
// Summary of operation
// - Auto send each externally triggered result.
// - Internal trigger: send on each trigger pulse.
// - Auto send off: results only when fetched.
// - Auto send drives serial port only.
// - Host-selected ASCII or binary format, readable.
// - Binary format omits the message delimiter.
// - Shorted-probe check enable, ON/OFF, readable.
// - Shorted-probe delay 1 to 100 ms.
// - Probe check starts after delay from end.
// - Retry enable, ON/OFF, readable.
// - Retry interval 1 to 50 ms.
// - System reset restores defaults, keeps comms/clock.
// - Save settings to non-volatile store afterward.
`timescale 1ns/100ps
`include "morc_map.svh"

module morc_core #(
  parameter int unsigned CYC_PER_MS = `MORC_MS_CYC  // Cycles per millisecond.
) (
  input  wire logic                   mclk,             // Instrument clock.
  input  wire logic                   rst_n,            // Asynchronous reset.
  input  wire logic                   clk_en,           // Freezes all state while low.
  input  wire logic                   cmd_set,          // Host set command strobe.
  input  wire logic                   cmd_query,        // Host query command strobe.
  input  wire morc_pkg::morc_cmd_t    cmd,              // Selector and value.
  input  wire logic                   sys_reset_cmd,    // System reset command strobe.
  input  wire logic                   trigger_input_signal_internal,    // Trigger source is internal.
  input  wire logic                   trigger_input_signal, // External trigger pin.
  input  wire logic                   meas_done,        // Measurement finished strobe.
  input  wire morc_pkg::morc_result_t meas_result,      // Its value and fault flag.
  input  wire logic                   host_fetch,       // Host asks for last result.
  input  wire logic                   host_fetch_gpib,  // That fetch came over GP-IB.
  input  wire logic                   tx_ready,         // Transmitter takes a word.
  output logic                        tx_valid,         // Word on tx_word is valid.
  output morc_pkg::morc_txword_t      tx_word,          // Head of the result buffer.
  output logic                        in_ready,         // Buffer can take a result.
  output logic                        auto_send_en,     // Auto send setting.
  output logic                        shorted_probe_check_enable, // Probe check on.
  output logic [7:0]                  shorted_probe_check_delay,  // Delay in ms.
  output logic                        probe_check_start, // Start probe check pulse.
  output logic                        meas_restart,     // Repeat measurement pulse.
  output logic                        nvm_save,         // Store settings pulse.
  output logic                        cmd_error,        // Rejected set or query command pulse.
  output logic                        query_valid,      // Query answer pulse.
  output logic [7:0]                  query_data        // Query answer.
);

  morc_pkg::morc_state_t s_q;  // Registered state.
  morc_pkg::morc_state_t s_d;  // Next state.

  // Loads a timer with a delay in milliseconds.
  function automatic morc_pkg::morc_timer_t tmr_start(input logic [7:0] ms);
    morc_pkg::morc_timer_t t;
    t.st  = morc_pkg::MORC_T_RUN;
    t.cyc = 20'h00000;
    t.ms  = ms;
    return t;
  endfunction

  // Advances a timer by one cycle; fire is high in the cycle it expires.
  function automatic morc_pkg::morc_timer_t tmr_step(input morc_pkg::morc_timer_t t,
                                                     output logic fire);
    morc_pkg::morc_timer_t n;
    n    = t;
    fire = 1'b0;
    case (t.st)
      // An idle timer keeps its value until it is loaded again.
      morc_pkg::MORC_T_IDLE: begin
        n = t;
      end
      // Count cycles up to a millisecond, then count the milliseconds down.
      morc_pkg::MORC_T_RUN: begin
        if (t.cyc == 20'(CYC_PER_MS - 1)) begin
          n.cyc = 20'h00000;
          // The last millisecond has run out: fire once and stop.
          if (t.ms <= 8'h01) begin
            n.ms  = 8'h00;
            n.st  = morc_pkg::MORC_T_IDLE;
            fire  = 1'b1;
          end else begin
            n.ms = t.ms - 8'h01;
          end
        end else begin
          n.cyc = t.cyc + 20'h00001;
        end
      end
      // A corrupt phase falls back to idle rather than running away.
      default: begin
        n.st = morc_pkg::MORC_T_IDLE;
      end
    endcase
    return n;
  endfunction

  // Builds a transmit word in the current format.
  function automatic morc_pkg::morc_txword_t mk_word(input morc_pkg::morc_result_t r,
                                                    input logic bin, input logic gpib);
    morc_pkg::morc_txword_t w;
    w.data    = r.data;
    w.fault   = r.fault;
    w.binary  = bin;
    w.delim   = ~bin;
    w.to_gpib = gpib;
    return w;
  endfunction

  // Next-state logic for settings, timers, result buffer and query answers.
  always_comb begin
    // Locals of the next-state logic, each given a value before any use.
    logic                   trigger_input_signal_edge;
    logic                   report;
    logic                   push;
    logic                   pop;
    logic                   spc_fire;
    logic                   retry_fire;
    morc_pkg::morc_txword_t word;
    trigger_input_signal_edge  = 1'b0;
    report     = 1'b0;
    push       = 1'b0;
    pop        = 1'b0;
    spc_fire   = 1'b0;
    retry_fire = 1'b0;
    word       = '0;
    s_d        = s_q;

    // Strobes last one cycle.
    s_d.spc_start    = 1'b0;
    s_d.meas_restart = 1'b0;
    s_d.nvm_save     = 1'b0;
    s_d.cmd_error    = 1'b0;
    s_d.query_valid  = 1'b0;

    // Trigger pin synchroniser; only the later stages feed the edge detector.
    s_d.trigger_input_signal_sync = {s_q.trigger_input_signal_sync[1:0], trigger_input_signal};
    trigger_input_signal_edge     = s_q.trigger_input_signal_sync[1] & ~s_q.trigger_input_signal_sync[2];
    // The first stage may be metastable, so it feeds nothing but the second.

    // Host set commands; out-of-range delays are refused and flagged.
    if (cmd_set) begin
      case (cmd.sel)
        `MORC_SEL_AUTO_SEND: s_d.auto_send = (cmd.value == `MORC_VAL_ON);
        `MORC_SEL_FORMAT:    s_d.binary    = (cmd.value == `MORC_VAL_ON);
        `MORC_SEL_SPC_EN:    s_d.spc_en    = (cmd.value == `MORC_VAL_ON);
        `MORC_SEL_RETRY_EN:  s_d.retry_en  = (cmd.value == `MORC_VAL_ON);
        // Delays outside the legal range are refused, never clamped, so the host sees it.
        `MORC_SEL_SPC_DLY: begin
          if (cmd.value >= `MORC_SPC_DLY_MIN && cmd.value <= `MORC_SPC_DLY_MAX) begin
            s_d.spc_dly = cmd.value;
          end else begin
            s_d.cmd_error = 1'b1;
          end
        end
        // Same range check for the retry interval, with its own upper bound.
        `MORC_SEL_RETRY_DLY: begin
          if (cmd.value >= `MORC_RETRY_DLY_MIN && cmd.value <= `MORC_RETRY_DLY_MAX) begin
            s_d.retry_dly = cmd.value;
          end else begin
            s_d.cmd_error = 1'b1;
          end
        end
        default: s_d.cmd_error = 1'b1;
      endcase
    end

    // Enable values other than 0 or 1 are errors, but still read as OFF.
    if (cmd_set && cmd.value > `MORC_VAL_ON && cmd.sel != `MORC_SEL_SPC_DLY &&
        cmd.sel != `MORC_SEL_RETRY_DLY) begin
      s_d.cmd_error = 1'b1;
    end

    // Query answers show the value in effect, in the set encoding.
    // A query and a set in one cycle answer with the value before the set.
    if (cmd_query) begin
      s_d.query_valid = 1'b1;
      case (cmd.sel)
        `MORC_SEL_AUTO_SEND: s_d.query_data = {7'h00, s_q.auto_send};
        `MORC_SEL_FORMAT:    s_d.query_data = {7'h00, s_q.binary};
        `MORC_SEL_SPC_EN:    s_d.query_data = {7'h00, s_q.spc_en};
        `MORC_SEL_SPC_DLY:   s_d.query_data = s_q.spc_dly;
        `MORC_SEL_RETRY_EN:  s_d.query_data = {7'h00, s_q.retry_en};
        `MORC_SEL_RETRY_DLY: s_d.query_data = s_q.retry_dly;
        default: begin
          s_d.query_data = 8'h00;
          s_d.cmd_error  = 1'b1;
        end
      endcase
    end

    // Timers run every cycle.
    s_d.spc_tmr   = tmr_step(s_q.spc_tmr, spc_fire);
    s_d.retry_tmr = tmr_step(s_q.retry_tmr, retry_fire);
    // A firing timer becomes a one-cycle pulse on the matching output.
    if (spc_fire) begin
      s_d.spc_start = 1'b1;
    end
    if (retry_fire) begin
      s_d.meas_restart = 1'b1;
      s_d.retried      = 1'b1;
    end

    // A finished measurement: a first fault is held back for one retry.
    if (meas_done) begin
      if (meas_result.fault && s_q.retry_en && !s_q.retried) begin
        s_d.retry_tmr = tmr_start(s_q.retry_dly);
      end else begin
        // Any other result is reported and frees the retry for the next fault.
        report        = 1'b1;
        s_d.retried   = 1'b0;
        s_d.last      = meas_result;
        s_d.have_last = 1'b1;
      end
      // Each new result restarts the probe check delay, so only the latest counts.
      if (s_q.spc_en) begin
        s_d.spc_tmr = tmr_start(s_q.spc_dly);
      end
    end

    // Pick at most one word to push; automatic output goes to the serial port only.
    // Priority is measurement, then trigger, then fetch; a losing request is lost.
    // A host fetch may go to either port, since it is not automatic output.
    if (s_q.auto_send && report && !trigger_input_signal_internal) begin
      push = 1'b1;
      word = mk_word(meas_result, s_q.binary, 1'b0);
    end else if (s_q.auto_send && trigger_input_signal_internal && trigger_input_signal_edge && s_q.have_last) begin
      push = 1'b1;
      word = mk_word(s_q.last, s_q.binary, 1'b0);
    end else if (host_fetch && s_q.have_last) begin
      push = 1'b1;
      word = mk_word(s_q.last, s_q.binary, host_fetch_gpib);
    end

    // Two-entry buffer; a push while full is dropped, which in_ready warns of.
    // The head is popped first, so a push in the same cycle lands behind it.
    pop = s_q.out_valid && tx_ready;
    if (pop) begin
      s_d.buf_q[0] = s_q.buf_q[1];
    end
    if (push && s_q.in_ready) begin
      if (s_q.cnt == 2'h0 || (s_q.cnt == 2'h1 && pop)) begin
        s_d.buf_q[0] = word;
      end else begin
        s_d.buf_q[1] = word;
      end
    end
    // Flags follow the new count so that both outputs come from flip-flops.
    s_d.cnt = s_q.cnt + 2'(push && s_q.in_ready) - 2'(pop);
    s_d.out_valid = (s_d.cnt != 2'h0);
    s_d.in_ready  = (s_d.cnt < 2'(`MORC_BUF_DEPTH));

    // System reset: defaults back, then a save request one cycle later.
    // Communication and clock settings live elsewhere, so nothing here keeps them.
    if (sys_reset_cmd) begin
      s_d.auto_send = `MORC_DEF_AUTO_SEND;
      s_d.binary    = `MORC_DEF_BINARY;
      s_d.spc_en    = `MORC_DEF_SPC_EN;
      s_d.spc_dly   = `MORC_DEF_SPC_DLY;
      s_d.retry_en  = `MORC_DEF_RETRY_EN;
      s_d.retry_dly = `MORC_DEF_RETRY_DLY;
      s_d.save_pend = 1'b1;
    end else if (s_q.save_pend) begin
      s_d.save_pend = 1'b0;
      s_d.nvm_save  = 1'b1;
    end
  end

  // State register; the clock enable freezes everything, strobes included.
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      // Settings start at their defaults; the empty buffer has room.
      s_q           <= '0;
      s_q.auto_send <= `MORC_DEF_AUTO_SEND;
      s_q.binary    <= `MORC_DEF_BINARY;
      s_q.spc_en    <= `MORC_DEF_SPC_EN;
      s_q.spc_dly   <= `MORC_DEF_SPC_DLY;
      s_q.retry_en  <= `MORC_DEF_RETRY_EN;
      s_q.retry_dly <= `MORC_DEF_RETRY_DLY;
      s_q.in_ready  <= 1'b1;
    end else if (clk_en) begin
      // A low enable holds every bit, so a pending pulse simply waits.
      s_q <= s_d;
    end
  end

  // Every output is a flip-flop of the state.
  assign tx_valid                   = s_q.out_valid;
  assign tx_word                    = s_q.buf_q[0];
  assign in_ready                   = s_q.in_ready;
  assign auto_send_en               = s_q.auto_send;
  assign shorted_probe_check_enable = s_q.spc_en;
  assign shorted_probe_check_delay  = s_q.spc_dly;
  assign probe_check_start          = s_q.spc_start;
  assign meas_restart               = s_q.meas_restart;
  assign nvm_save                   = s_q.nvm_save;
  assign cmd_error                  = s_q.cmd_error;
  assign query_valid                = s_q.query_valid;
  assign query_data                 = s_q.query_data;

endmodule // morc_core

/* logic/morc_map.svh */
// Offsets, codes, defaults and timing counts of the measurement output and retry settings.
// Assumes a single 125 MHz instrument clock; included by bare name wherever needed.
`ifndef MORC_MAP_SVH
`define MORC_MAP_SVH

// Clock period and the millisecond unit, both in nanoseconds.
`define MORC_CLK_PERIOD_NS 8
`define MORC_MS_NS         1000000
// Cycles in one millisecond; both delay settings are held in milliseconds.
`define MORC_MS_CYC        (`MORC_MS_NS / `MORC_CLK_PERIOD_NS)

// Setting selector codes carried by a host set or query command.
`define MORC_SEL_AUTO_SEND 3'h0
`define MORC_SEL_FORMAT    3'h1
`define MORC_SEL_SPC_EN    3'h2
`define MORC_SEL_SPC_DLY   3'h3
`define MORC_SEL_RETRY_EN  3'h4
`define MORC_SEL_RETRY_DLY 3'h5

// Value encodings: 1 means ON, or BINARY for the format setting.
`define MORC_VAL_ON        8'h01
`define MORC_VAL_OFF       8'h00

// Legal ranges in milliseconds (0.001 to 0.1 s and 0.001 to 0.05 s).
`define MORC_SPC_DLY_MIN   8'h01
`define MORC_SPC_DLY_MAX   8'h64
`define MORC_RETRY_DLY_MIN 8'h01
`define MORC_RETRY_DLY_MAX 8'h32

// Defaults restored by reset and by the system reset command.
`define MORC_DEF_AUTO_SEND 1'b0
`define MORC_DEF_BINARY    1'b0
`define MORC_DEF_SPC_EN    1'b0
`define MORC_DEF_SPC_DLY   8'h0A
`define MORC_DEF_RETRY_EN  1'b0
`define MORC_DEF_RETRY_DLY 8'h0A

// Depth of the result buffer in front of the transmitters.
`define MORC_BUF_DEPTH     2

`endif

/* logic/morc_pkg.sv */
// Types shared by the measurement output and retry settings block.
// Assumes the constants of morc_map.svh; holds types only.
package morc_pkg;

  // Host set or query command: which setting and the encoded value.
  typedef struct packed {
    logic [2:0] sel;
    logic [7:0] value;
  } morc_cmd_t;

  // One finished measurement from the analog front end.
  typedef struct packed {
    logic [31:0] data;
    logic        fault;
  } morc_result_t;

  // One word handed to a transmitter.
  typedef struct packed {
    logic [31:0] data;
    logic        fault;
    logic        binary;
    logic        delim;
    logic        to_gpib;
  } morc_txword_t;

  // Delay timer phases.
  typedef enum logic [0:0] {
    MORC_T_IDLE,
    MORC_T_RUN
  } morc_tstate_t;

  // A millisecond delay timer.
  typedef struct packed {
    morc_tstate_t st;
    logic [19:0]  cyc;
    logic [7:0]   ms;
  } morc_timer_t;

  // Every flip-flop of the block.
  typedef struct packed {
    logic              auto_send;
    logic              binary;
    logic              spc_en;
    logic [7:0]        spc_dly;
    logic              retry_en;
    logic [7:0]        retry_dly;
    logic [2:0]        trigger_input_signal_sync;
    morc_result_t      last;
    logic              have_last;
    logic              retried;
    morc_timer_t       spc_tmr;
    morc_timer_t       retry_tmr;
    morc_txword_t [1:0] buf_q;
    logic [1:0]        cnt;
    logic              out_valid;
    logic              in_ready;
    logic              spc_start;
    logic              meas_restart;
    logic              nvm_save;
    logic              save_pend;
    logic              cmd_error;
    logic              query_valid;
    logic [7:0]        query_data;
  } morc_state_t;

endpackage
